// ===== rtl/link_framer_pkg.sv
// Shared constants for the 64b/66b transmit framer
package link_framer_pkg;
  localparam int BLOCK_BITS = 64;
  localparam int LINE_BITS = 66;
  localparam int HDR_BITS = 2;
  localparam int OCTET_BITS = 8;
  localparam int BLOCKS_PER_MB = 32;
  localparam int IDX_BITS = 5;
  localparam int EMB_BITS = 8;
  localparam int STREAM_BITS = 32;
  localparam int CRC_BITS = 12;
  localparam int FEC_BITS = 26;
  localparam int SCR_BITS = 58;
  // Scrambler taps 1 + x^39 + x^58, as zero-based state indices
  localparam int SCR_TAP_A = 38;
  localparam int SCR_TAP_B = 57;
  // Generator in short form (implicit +1), expanded to low-order taps
  localparam logic [11:0] CRC_POLY_SHORT = 12'h987;
  localparam logic [11:0] CRC_POLY_LOW = {CRC_POLY_SHORT[10:0], 1'b1};
  localparam logic [25:0] FEC_POLY_LOW = 26'h0220211;
  // Header stream mode codes
  localparam logic [1:0] MODE_CRC12 = 2'h0;
  localparam logic [1:0] MODE_FEC = 2'h2;
  // Header stream positions
  localparam logic [4:0] POS_EEMB = 5'h16;
  localparam logic [4:0] POS_LAST = 5'h1F;
  localparam logic [4:0] POS_MULTIBLOCK_END_PATTERN_FIRST = 5'h1B;
  // Fixed ones of CRC mode at 3,7,11,15,19,21,23,31
  localparam logic [31:0] CRC_ONES_MASK = 32'h80A88888;
  // Command bit positions of CRC mode at 16,17,18,20,24,25,26
  localparam logic [31:0] CMD_MASK = 32'h07170000;
  // Sync header values: 01 carries one, 10 carries zero (bit 0 first)
  localparam logic [1:0] HDR_ONE = 2'h2;
  localparam logic [1:0] HDR_ZERO = 2'h1;
endpackage

// ===== rtl/block_scrambler.sv
// Self-synchronous 64-bit block scrambler, first line bit in bit 63
`timescale 1ns/10ps
`default_nettype none
module block_scrambler (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Block in, scrambled block out
  input wire logic step_in,
  input wire logic [link_framer_pkg::BLOCK_BITS-1:0] data_in,
  output logic [link_framer_pkg::BLOCK_BITS-1:0] scr_out
);
  logic [link_framer_pkg::SCR_BITS-1:0] state_reg;
  logic [link_framer_pkg::SCR_BITS-1:0] state_next;

  // Bit-serial recurrence unrolled over the block, oldest bit first
  always_comb begin
    logic [link_framer_pkg::SCR_BITS-1:0] st;
    logic b;
    st = state_reg;
    b = 1'b0;
    scr_out = '0;
    for (int i = link_framer_pkg::BLOCK_BITS - 1; i >= 0; i--) begin
      b = data_in[i] ^ st[link_framer_pkg::SCR_TAP_A] ^ st[link_framer_pkg::SCR_TAP_B];
      scr_out[i] = b;
      st = {st[link_framer_pkg::SCR_BITS-2:0], b};
    end
    state_next = st;
  end

  // State moves only when a block is taken
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else if (step_in) begin
      state_reg <= state_next;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/parity_lfsr.sv
// Block-wide parity shift register for CRC and FEC words
`timescale 1ns/10ps
`default_nettype none
module parity_lfsr #(
  parameter int WIDTH = 12,
  parameter logic [WIDTH-1:0] POLY = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // One block per step; first restarts from zero
  input wire logic step_in,
  input wire logic first_in,
  input wire logic [link_framer_pkg::BLOCK_BITS-1:0] data_in,
  output logic [WIDTH-1:0] parity_out
);
  // Divide 64 bits into the running remainder, oldest bit first
  function automatic logic [WIDTH-1:0] advance(input logic [WIDTH-1:0] seed,
                                              input logic [link_framer_pkg::BLOCK_BITS-1:0] d);
    logic [WIDTH-1:0] st;
    logic fb;
    st = seed;
    for (int i = link_framer_pkg::BLOCK_BITS - 1; i >= 0; i--) begin
      fb = st[WIDTH-1] ^ d[i];
      st = {st[WIDTH-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    return st;
  endfunction

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      parity_out <= '0;
    end else if (step_in) begin
      parity_out <= advance(first_in ? '0 : parity_out, data_in);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/link_framer.sv
// 64b/66b transmit framer: blocks, multiblocks, header stream, parity
`timescale 1ns/10ps
`default_nettype none
module link_framer #(
  parameter int EMB_W = link_framer_pkg::EMB_BITS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Transport side: one 64-bit block per valid cycle, octet 0 in bits 63:56
  input wire logic block_valid_in,
  input wire logic [link_framer_pkg::BLOCK_BITS-1:0] block_data_in,
  // Configuration levels
  input wire logic [1:0] header_stream_mode_select_in,
  input wire logic [EMB_W-1:0] emb_count_in,
  // System reference pin, asynchronous
  input wire logic sysref_in,
  // Line side: 66-bit block, bit 0 sent first
  output logic line_valid_out,
  output logic [link_framer_pkg::LINE_BITS-1:0] line_block_out,
  output logic local_extended_block_clock_out,
  output logic extended_block_end_flag_out
);
  logic sref_s1_reg;
  logic sref_s2_reg;
  logic sref_s3_reg;
  logic sref_level_reg;
  logic sref_rise;
  logic sref_pending_reg;
  logic [link_framer_pkg::IDX_BITS-1:0] blk_idx_reg;
  logic [EMB_W-1:0] mb_idx_reg;
  logic [EMB_W-1:0] emb_last;
  logic [1:0] mode_reg;
  logic [1:0] mode_now;
  logic [link_framer_pkg::BLOCK_BITS-1:0] scr_word;
  logic [link_framer_pkg::CRC_BITS-1:0] crc_par;
  logic [link_framer_pkg::FEC_BITS-1:0] fec_par;
  logic [link_framer_pkg::CRC_BITS-1:0] crc_hold_reg;
  logic [link_framer_pkg::FEC_BITS-1:0] fec_hold_reg;
  logic [link_framer_pkg::CRC_BITS-1:0] crc_use;
  logic [link_framer_pkg::FEC_BITS-1:0] fec_use;
  logic first_blk;
  logic last_mb;
  logic [link_framer_pkg::STREAM_BITS-1:0] stream_word;
  logic stream_bit;
  logic [link_framer_pkg::IDX_BITS-1:0] out_idx_reg;
  logic [1:0] out_mode_reg;

  // Stream word for one multiblock; index equals stream bit position
  // CRC-12 or FEC only, no command channel
  function automatic logic [link_framer_pkg::STREAM_BITS-1:0] build_stream(
      input logic [1:0] mode, input logic [link_framer_pkg::CRC_BITS-1:0] crc,
      input logic [link_framer_pkg::FEC_BITS-1:0] fec, input logic eemb);
    logic [link_framer_pkg::STREAM_BITS-1:0] w;
    w = '0;
    if (mode == link_framer_pkg::MODE_FEC) begin
      for (int i = 0; i < 22; i++) begin
        w[i] = fec[25 - i];
      end
      w[23] = fec[3];
      w[24] = fec[2];
      w[25] = fec[1];
      w[26] = fec[0];
    end else begin
      w = link_framer_pkg::CRC_ONES_MASK;
      w[0] = crc[11];
      w[1] = crc[10];
      w[2] = crc[9];
      w[4] = crc[8];
      w[5] = crc[7];
      w[6] = crc[6];
      w[8] = crc[5];
      w[9] = crc[4];
      w[10] = crc[3];
      w[12] = crc[2];
      w[13] = crc[1];
      w[14] = crc[0];
      w = w & ~link_framer_pkg::CMD_MASK;
    end
    w[30:27] = 4'h0;
    w[link_framer_pkg::POS_LAST] = 1'b1;
    w[link_framer_pkg::POS_EEMB] = eemb;
    return w;
  endfunction

  // Scrambled word into line positions 2..65, first line bit = bit 63
  function automatic logic [link_framer_pkg::BLOCK_BITS-1:0] to_line(
      input logic [link_framer_pkg::BLOCK_BITS-1:0] s);
    logic [link_framer_pkg::BLOCK_BITS-1:0] r;
    r = '0;
    for (int i = 0; i < link_framer_pkg::BLOCK_BITS; i++) begin
      r[i] = s[link_framer_pkg::BLOCK_BITS - 1 - i];
    end
    return r;
  endfunction

  // Three-stage reference synchroniser; stage one feeds stage two only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sref_s1_reg <= 1'b0;
      sref_s2_reg <= 1'b0;
      sref_s3_reg <= 1'b0;
      sref_level_reg <= 1'b0;
    end else begin
      sref_s1_reg <= sysref_in;
      sref_s2_reg <= sref_s1_reg;
      sref_s3_reg <= sref_s2_reg;
      if (sref_s2_reg == sref_s3_reg) begin
        sref_level_reg <= sref_s3_reg;
      end
    end
  end

  assign sref_rise = (sref_s2_reg == sref_s3_reg) && sref_s3_reg && !sref_level_reg;

  // Reference edge waits for the next block so none is lost between blocks
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sref_pending_reg <= 1'b0;
    end else if (sref_rise) begin
      sref_pending_reg <= 1'b1;
    end else if (block_valid_in) begin
      sref_pending_reg <= 1'b0;
    end
  end

  // E of zero behaves as one
  assign emb_last = (emb_count_in == '0) ? '0 : emb_count_in - EMB_W'(1);
  // a pending reference forces phase zero
  assign first_blk = sref_pending_reg || (blk_idx_reg == '0);
  assign last_mb = sref_pending_reg ? (emb_last == '0) : (mb_idx_reg >= emb_last);
  // Mode is sampled at a multiblock start so one word never mixes layouts
  assign mode_now = first_blk ? header_stream_mode_select_in : mode_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      blk_idx_reg <= '0;
      mb_idx_reg <= '0;
      mode_reg <= link_framer_pkg::MODE_CRC12;
    end else if (block_valid_in) begin
      mode_reg <= mode_now;
      if (sref_pending_reg) begin
        blk_idx_reg <= link_framer_pkg::IDX_BITS'(1);
        mb_idx_reg <= '0;
      end else begin
        blk_idx_reg <= blk_idx_reg + link_framer_pkg::IDX_BITS'(1);
        if (blk_idx_reg == link_framer_pkg::POS_LAST) begin
          mb_idx_reg <= (mb_idx_reg >= emb_last) ? '0 : mb_idx_reg + EMB_W'(1);
        end
      end
    end
  end

  // scramble before the header is added
  block_scrambler u_scr (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .step_in(block_valid_in),
    .data_in(block_data_in),
    .scr_out(scr_word)
  );

  parity_lfsr #(.WIDTH(link_framer_pkg::CRC_BITS), .POLY(link_framer_pkg::CRC_POLY_LOW)) u_crc (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .step_in(block_valid_in),
    .first_in(first_blk),
    .data_in(scr_word),
    .parity_out(crc_par)
  );

  parity_lfsr #(.WIDTH(link_framer_pkg::FEC_BITS), .POLY(link_framer_pkg::FEC_POLY_LOW)) u_fec (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .step_in(block_valid_in),
    .first_in(first_blk),
    .data_in(scr_word),
    .parity_out(fec_par)
  );

  // previous multiblock's parity held for this one's stream
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crc_hold_reg <= '0;
      fec_hold_reg <= '0;
    end else if (block_valid_in && first_blk) begin
      crc_hold_reg <= crc_par;
      fec_hold_reg <= fec_par;
    end
  end

  assign crc_use = first_blk ? crc_par : crc_hold_reg;
  assign fec_use = first_blk ? fec_par : fec_hold_reg;
  assign stream_word = build_stream(mode_now, crc_use, fec_use, last_mb);
  assign stream_bit = stream_word[sref_pending_reg ? '0 : blk_idx_reg];

  // line block assembly; header is 01 or 10 by bit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_valid_out <= 1'b0;
      line_block_out <= '0;
    end else begin
      line_valid_out <= block_valid_in;
      if (block_valid_in) begin
        line_block_out <= {to_line(scr_word),
                           stream_bit ? link_framer_pkg::HDR_ONE : link_framer_pkg::HDR_ZERO};
      end
    end
  end

  // extended multiblock clock pulse and end flag, aligned to the block
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      local_extended_block_clock_out <= 1'b0;
      extended_block_end_flag_out <= 1'b0;
      out_idx_reg <= '0;
      out_mode_reg <= link_framer_pkg::MODE_CRC12;
    end else begin
      local_extended_block_clock_out <= block_valid_in && first_blk &&
                                        (sref_pending_reg || mb_idx_reg == '0);
      if (block_valid_in) begin
        extended_block_end_flag_out <= last_mb;
        out_idx_reg <= sref_pending_reg ? '0 : blk_idx_reg;
        out_mode_reg <= mode_now;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_HDR_DIFF: assert property (line_valid_out |-> line_block_out[0] != line_block_out[1])
    else $error("header bits equal");
  // First scrambled bit lands right after the header, last at the top
  AST_PACK: assert property (block_valid_in ##1 1'b1 |->
      line_block_out[2] == $past(scr_word[link_framer_pkg::BLOCK_BITS-1])
      && line_block_out[link_framer_pkg::LINE_BITS-1] == $past(scr_word[0]))
    else $error("payload placement wrong");
  AST_MULTIBLOCK_END_PATTERN_ZERO: assert property (line_valid_out
      && out_idx_reg >= link_framer_pkg::POS_MULTIBLOCK_END_PATTERN_FIRST
      && out_idx_reg != link_framer_pkg::POS_LAST |-> line_block_out[1] == 1'b0)
    else $error("end pattern zero missing");
  AST_MULTIBLOCK_END_PATTERN_ONE: assert property (line_valid_out
      && out_idx_reg == link_framer_pkg::POS_LAST |-> line_block_out[1])
    else $error("end pattern one missing");
  AST_EEMB: assert property (line_valid_out
      && out_idx_reg == link_framer_pkg::POS_EEMB
      |-> line_block_out[1] == extended_block_end_flag_out)
    else $error("extended end bit wrong");
  AST_CRC_ONES: assert property (line_valid_out
      && out_mode_reg != link_framer_pkg::MODE_FEC
      && link_framer_pkg::CRC_ONES_MASK[out_idx_reg] |-> line_block_out[1])
    else $error("fixed one missing");
  AST_CMD_ZERO: assert property (line_valid_out
      && out_mode_reg != link_framer_pkg::MODE_FEC
      && link_framer_pkg::CMD_MASK[out_idx_reg] |-> !line_block_out[1])
    else $error("command bit set");
  AST_CRC_MSB: assert property (line_valid_out
      && out_mode_reg == link_framer_pkg::MODE_CRC12
      && out_idx_reg == '0 |-> line_block_out[1] == crc_hold_reg[11])
    else $error("parity msb not from previous multiblock");
  AST_MB_WRAP: assert property (block_valid_in && !sref_pending_reg && !sref_rise
      && blk_idx_reg == link_framer_pkg::POS_LAST ##1 block_valid_in |-> first_blk)
    else $error("multiblock not 32 blocks");
  AST_SREF_PHASE: assert property (block_valid_in && sref_pending_reg
      |=> local_extended_block_clock_out && out_idx_reg == '0)
    else $error("reference did not reset phase");

  COV_LOCAL_EXTENDED_BLOCK_CLOCK: cover property (local_extended_block_clock_out);
  COV_FEC: cover property (line_valid_out && out_mode_reg == link_framer_pkg::MODE_FEC);
  COV_EEMB: cover property (line_valid_out && extended_block_end_flag_out
      && out_idx_reg == link_framer_pkg::POS_LAST);
  COV_SREF: cover property (sref_rise);
endmodule
`default_nettype wire

// ===== bench/rx_link_model.sv
// Far-end receiver model: header, pilot and parity checks
`timescale 1ns/10ps
`default_nettype none
module rx_link_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Line side and controls
  input wire logic line_valid_in,
  input wire logic [link_framer_pkg::LINE_BITS-1:0] line_block_in,
  input wire logic [1:0] mode_in,
  input wire logic sysref_in,
  // Error tally
  output logic [15:0] err_count_out
);
  logic [4:0] idx_reg;
  logic [31:0] sh_reg;
  logic [11:0] crc_reg, crc_prev_reg;
  logic [25:0] fec_reg, fec_prev_reg;
  logic fm_reg, sref_reg, pend_reg;

  // Behavioural receiver; blocking updates keep it short
  always @(posedge clk_in or negedge rst_n_in) begin
    logic [31:0] s;
    logic [11:0] c;
    logic [25:0] f;
    logic [25:0] g;
    if (!rst_n_in) begin
      idx_reg = '0;
      sh_reg = '0;
      crc_reg = '0;
      crc_prev_reg = '0;
      fec_reg = '0;
      fec_prev_reg = '0;
      fm_reg = 1'b0;
      sref_reg = 1'b0;
      pend_reg = 1'b0;
      err_count_out = '0;
    end else begin
      if (line_valid_in) begin
        // block after a reference edge is block zero; partial parity goes next
        if (pend_reg) begin
          idx_reg = '0;
          crc_prev_reg = crc_reg;
          fec_prev_reg = fec_reg;
          pend_reg = 1'b0;
        end
        // 00 or 11 hints at lost block alignment
        if (line_block_in[1:0] !== 2'b01 && line_block_in[1:0] !== 2'b10) err_count_out++;
        if (idx_reg == 0) fm_reg = (mode_in == 2'h2);
        c = (idx_reg == 0) ? 12'h000 : crc_reg;
        f = (idx_reg == 0) ? 26'h0000000 : fec_reg;
        s = sh_reg;
        s[idx_reg] = line_block_in[1];
        for (int i = 0; i < 64; i++) begin
          c = {c[10:0], 1'b0} ^ ((line_block_in[2+i] ^ c[11]) ? 12'h30F : 12'h000);
          f = {f[24:0], 1'b0} ^ ((line_block_in[2+i] ^ f[25]) ? 26'h0220211 : 26'h0000000);
        end
        // compare as soon as the carried word is complete
        if (idx_reg == 14 && !fm_reg && {s[0], s[1], s[2], s[4], s[5], s[6], s[8], s[9],
            s[10], s[12], s[13], s[14]} !== crc_prev_reg) err_count_out++;
        for (int j = 0; j < 22; j++) g[25-j] = s[j];
        for (int j = 0; j < 4; j++) g[3-j] = s[23+j];
        if (idx_reg == 26 && fm_reg && g !== fec_prev_reg) err_count_out++;
        // Boundary pilot must close every word
        if (idx_reg == 31 && s[31:27] !== 5'h10) err_count_out++;
        if (idx_reg == 31) begin
          crc_prev_reg = c;
          fec_prev_reg = f;
        end
        crc_reg = c;
        fec_reg = f;
        sh_reg = s;
        idx_reg = idx_reg + 5'h01;
      end
      // Edge acts from the next block; assumes the line idles around the reference
      if (sysref_in && !sref_reg) pend_reg = 1'b1;
      sref_reg = sysref_in;
    end
  end
endmodule
`default_nettype wire

// ===== bench/link_framer_tb.sv
// Self-checking bench for the 64b/66b transmit framer
`timescale 1ns/10ps
`default_nettype none
module link_framer_tb;
  typedef struct {
    logic [1:0] mode;
    logic [7:0] emb;
    int gap;
    int n_mb;
    logic [15:0] exp_ends;
    logic [15:0] exp_local_extended_block_clock;
  } row_type;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  logic [63:0] data = 64'h0;
  logic [1:0] mode = 2'h0;
  logic [7:0] emb = 8'h01;
  logic sysref = 1'b0;
  logic line_valid, local_extended_block_clock, eemb;
  logic [65:0] line_block;
  logic [15:0] rx_err, obs_ends, obs_local_extended_block_clock;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  // Reference state of the bench model
  logic [57:0] scr;
  logic [11:0] crc_acc, crc_last;
  logic [25:0] fec_acc, fec_last;
  logic [31:0] sh_word;
  int idx, mb_pos, blk_cnt;
  row_type rows [4];

  link_framer u_dut (
    .clk_in(clk), .rst_n_in(rst_n), .block_valid_in(valid), .block_data_in(data),
    .header_stream_mode_select_in(mode), .emb_count_in(emb), .sysref_in(sysref),
    .line_valid_out(line_valid), .line_block_out(line_block),
    .local_extended_block_clock_out(local_extended_block_clock), .extended_block_end_flag_out(eemb)
  );
  rx_link_model u_rx (
    .clk_in(clk), .rst_n_in(rst_n), .line_valid_in(line_valid), .line_block_in(line_block),
    .mode_in(mode), .sysref_in(sysref), .err_count_out(rx_err)
  );

  always #5 clk = ~clk;

  // Cut a hung run short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      $display("CHECK FAILED run_length expected %0d seen %0d", 1999, cycles);
      print_verdict();
    end
  end

  task automatic check_block(input string nm, input logic [65:0] e, input logic [65:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic check_bit(input string nm, input logic e, input logic s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic check_count(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, s);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic model_reset();
    scr = '0;
    crc_acc = '0;
    crc_last = '0;
    fec_acc = '0;
    fec_last = '0;
    idx = 0;
    mb_pos = 0;
  endtask

  // stream word built from the tables
  function automatic logic [31:0] build_word(input logic [1:0] m, input logic last);
    logic [31:0] w;
    int p;
    w = 32'h80000000;
    w[22] = last;
    p = 0;
    if (m == 2'h2) begin
      for (int j = 0; j < 22; j++) w[j] = fec_last[25-j];
      for (int j = 0; j < 4; j++) w[23+j] = fec_last[3-j];
    end else begin
      w = w | 32'h00A88888;
      for (int j = 11; j >= 0; j--) begin
        if (p % 4 == 3) p++;
        w[p] = crc_last[j];
        p++;
      end
    end
    return w;
  endfunction

  task automatic model_block(input logic [63:0] d, output logic [65:0] ln,
                             output logic le, output logic ee);
    int e;
    logic b;
    e = (emb == 8'h00) ? 1 : int'(emb);
    ee = (mb_pos == e - 1);
    le = (idx == 0 && mb_pos == 0);
    if (idx == 0) sh_word = build_word(mode, ee);
    for (int i = 0; i < 64; i++) begin
      b = d[63-i] ^ scr[38] ^ scr[57];
      scr = {scr[56:0], b};
      ln[2+i] = b;
      crc_acc = {crc_acc[10:0], 1'b0} ^ ((b ^ crc_acc[11]) ? 12'h30F : 12'h000);
      fec_acc = {fec_acc[24:0], 1'b0} ^ ((b ^ fec_acc[25]) ? 26'h0220211 : 26'h0000000);
    end
    // 01 carries one, 10 carries zero
    ln[1] = sh_word[idx];
    ln[0] = ~sh_word[idx];
    idx++;
    if (idx == 32) begin
      idx = 0;
      crc_last = crc_acc;
      fec_last = fec_acc;
      crc_acc = '0;
      fec_acc = '0;
      mb_pos = (mb_pos + 1 >= e) ? 0 : mb_pos + 1;
    end
  endtask

  task automatic send_block(input logic [63:0] d, input int gap);
    logic [65:0] xl;
    logic xle, xee;
    model_block(d, xl, xle, xee);
    valid = 1'b1;
    data = d;
    @(negedge clk);
    check_bit("line_valid", 1'b1, line_valid);
    check_block("line_block", xl, line_block);
    check_bit("local_extended_block_clock", xle, local_extended_block_clock);
    check_bit("eemb_flag", xee, eemb);
    if (eemb === 1'b1) obs_ends++;
    if (local_extended_block_clock === 1'b1) obs_local_extended_block_clock++;
    if (gap > 0) begin
      valid = 1'b0;
      repeat (gap) begin
        @(negedge clk);
        check_bit("idle_valid", 1'b0, line_valid);
        check_bit("idle_local_extended_block_clock", 1'b0, local_extended_block_clock);
      end
    end
  endtask

  task automatic run_blocks(input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      send_block({32'(blk_cnt * 32'h9E3779B9), 32'(blk_cnt) ^ 32'hA5A5F00F}, gap);
      blk_cnt++;
    end
  endtask

  initial begin
    rows[0] = '{2'h0, 8'h02, 0, 2, 16'h0020, 16'h0001};
    rows[1] = '{2'h2, 8'h01, 0, 2, 16'h0040, 16'h0002};
    rows[2] = '{2'h1, 8'h00, 1, 1, 16'h0020, 16'h0001};
    rows[3] = '{2'h3, 8'h03, 0, 3, 16'h0020, 16'h0001};
    blk_cnt = 0;
    model_reset();
    repeat (12) @(negedge clk);
    // Outputs stay quiet while reset is held
    check_bit("reset_valid", 1'b0, line_valid);
    check_block("reset_block", 66'h0, line_block);
    $display("reset hold test done, mismatches %0d", fails);
    rst_n = 1'b1;
    // every mode code and several multiblock counts
    foreach (rows[r]) begin
      mode = rows[r].mode;
      emb = rows[r].emb;
      obs_ends = '0;
      obs_local_extended_block_clock = '0;
      run_blocks(32 * rows[r].n_mb, rows[r].gap);
      check_count("eemb_blocks", rows[r].exp_ends, obs_ends);
      check_count("local_extended_block_clock_pulses", rows[r].exp_local_extended_block_clock, obs_local_extended_block_clock);
      $display("row %0d done, mismatches %0d", r, fails);
    end
    // one reference pulse mid multiblock restarts the phase
    run_blocks(10, 0);
    valid = 1'b0;
    sysref = 1'b1;
    repeat (2) @(negedge clk);
    sysref = 1'b0;
    repeat (5) @(negedge clk);
    crc_last = crc_acc;
    fec_last = fec_acc;
    crc_acc = '0;
    fec_acc = '0;
    idx = 0;
    mb_pos = 0;
    run_blocks(64, 0);
    // Let the receiver see the last block before reading its tally
    valid = 1'b0;
    @(negedge clk);
    check_count("rx_errors", 16'h0000, rx_err);
    $display("realign test done, mismatches %0d", fails);
    // Reset at a multiblock boundary clears scrambler and parity
    valid = 1'b0;
    rst_n = 1'b0;
    @(negedge clk);
    check_bit("reset_valid", 1'b0, line_valid);
    check_block("reset_block", 66'h0, line_block);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    model_reset();
    run_blocks(40, 0);
    valid = 1'b0;
    @(negedge clk);
    check_count("rx_errors", 16'h0000, rx_err);
    $display("reset test done, mismatches %0d", fails);
    print_verdict();
  end
endmodule
`default_nettype wire
